// *** include/coc_link_if.sv ***
// serial programming and control pins between host and device
// assumes both ends run on the same clock
`timescale 1ns/10ps
interface coc_link_if;
  logic serialClk;
  logic serialData;
  logic latchEn;
  logic syncN;
  logic global_enable_pin;
  logic lockPin;
  modport host (output serialClk, output serialData, output latchEn,
                output syncN, output global_enable_pin, input lockPin);
  modport device (input serialClk, input serialData, input latchEn,
                  input syncN, input global_enable_pin, output lockPin);
endinterface

// *** include/coc_pkg.sv ***
// constants shared by both ends of the clock output control link
// assumes a single 40 MHz system clock on both ends
package coc_pkg;
  // programming word layout
  localparam int         WORD_W      = 32;
  localparam int         ADDR_W      = 4;
  localparam int         NUM_OUT     = 8;
  localparam logic [3:0] ADDR_R11    = 4'hB;
  localparam logic [3:0] ADDR_R14    = 4'hE;
  localparam logic [3:0] ADDR_R15    = 4'hF;
  localparam int         RESET_BIT   = 31;
  localparam int         MUX_LSB     = 17;
  localparam int         EN_BIT      = 16;
  localparam int         DIV_LSB     = 8;
  localparam int         DLY_LSB     = 4;
  localparam int         LOCK_DETECT_PRESCALE_BIT    = 15;
  localparam int         GEN_BIT     = 27;
  localparam int         PDN_BIT     = 26;
  localparam int         PLLMUX_LSB  = 20;
  localparam int         VCODIV_LSB  = 26;
  // path select codes
  localparam logic [1:0] MUX_BYPASS  = 2'h0;
  localparam logic [1:0] MUX_DIV     = 2'h1;
  localparam logic [1:0] MUX_DLY     = 2'h2;
  localparam logic [1:0] MUX_DIVDLY  = 2'h3;
  // reset values and lock pin output codes
  localparam logic [1:0] MUX_RST     = 2'h0;
  localparam logic [7:0] DIV_RST     = 8'h01;
  localparam logic [3:0] DLY_RST     = 4'h0;
  localparam logic [3:0] VCODIV_RST  = 4'h2;
  localparam logic [3:0] PLLMUX_RST  = 4'h0;
  localparam logic       GEN_RST     = 1'b1;
  localparam logic [3:0] LD_ACT_HIGH = 4'h3;
  localparam logic [3:0] LD_ACT_LOW  = 4'h4;
  // delay step
  localparam int         DLY_STEP_PS = 150;
  localparam int         DLY_MAX_PS  = 2250;
  // lock detect
  localparam logic [7:0] LOCK_EPS_NS = 8'h0A;
  localparam logic [7:0] LOCK_DEL_NS = 8'h14;
  localparam logic [2:0] LOCK_COUNT  = 3'h5;
  localparam logic [1:0] LD_PRESCALE = 2'h3;
  // sync lag in distribution cycles
  localparam int         SYNC_LAG    = 4;
  // host timing
  localparam int         CLK_MHZ     = 40;
  localparam int         T_CWH_NS    = 25;
  localparam int         HALF_CYC    = (T_CWH_NS * CLK_MHZ + 999) / 1000;
  // host wishbone map
  localparam logic [3:0] WB_WORD     = 4'h0;
  localparam logic [3:0] WB_STATUS   = 4'h4;
  localparam logic [3:0] WB_CTRL     = 4'h8;
  localparam logic [1:0] CTRL_RST    = 2'h3;
endpackage

// *** rtl/coc_channel.sv ***
// one clock output: divider, sync hold, enable gating, delay report
// assumes distTick marks each distribution-path rising edge
`timescale 1ns/10ps
module coc_channel (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // distribution path
  input  wire logic        distTick,
  input  wire logic        distLevel,
  input  wire logic        syncHold,
  input  wire logic        syncRelease,
  // settings
  input  wire logic [1:0]  mux,
  input  wire logic [7:0]  div,
  input  wire logic [3:0]  dly,
  input  wire logic        enable,
  input  wire logic        global_enable_pin,
  // output
  output logic             clkOut,
  output logic             outOn,
  output logic [11:0]      delayPs
);
  logic [6:0] cnt;
  logic       divLevel;
  logic       divided;
  logic       level;

  assign divided = (mux == coc_pkg::MUX_DIV) || (mux == coc_pkg::MUX_DIVDLY);

  // even divide toggles every div/2 ticks, so duty stays 50%
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt      <= 7'h00;
      divLevel <= 1'b0;
    end else if (syncHold) begin
      cnt      <= 7'h00;
      divLevel <= 1'b0;
    end else if (syncRelease) begin
      cnt      <= 7'h00;
      divLevel <= 1'b1;
    end else if (distTick) begin
      if (cnt + 7'h01 >= div[7:1]) begin
        cnt      <= 7'h00;
        divLevel <= ~divLevel;
      end else begin
        cnt <= cnt + 7'h01;
      end
    end
  end

  // divide by one follows the distribution clock, still gated by sync
  always_comb begin
    if (!divided) level = distLevel;
    else if (div < 8'h02) level = distLevel & ~syncHold;
    else level = divLevel;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      clkOut  <= 1'b0;
      outOn   <= 1'b0;
      delayPs <= 12'h000;
    end else begin
      outOn   <= enable;
      clkOut  <= enable & global_enable_pin & level;
      delayPs <= 12'(32'(dly) * coc_pkg::DLY_STEP_PS);
    end
  end
endmodule // coc_channel

// *** rtl/coc_device.sv ***
// device end: serial register load, output distribution, sync, lock detect
// assumes link pins synchronous to clk; distribution clock made from clk
//
// The address map and register access over Wishbone were decided locally.
`timescale 1ns/10ps
module coc_device (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // link
  coc_link_if.device        link,
  // reference and phase detector
  input  wire logic         refTick,
  input  wire logic [7:0]   phaseErrNs,
  // clock outputs
  output logic [7:0]        clkOut,
  output logic [7:0]        outOn,
  output logic [7:0][11:0]  outDelayPs,
  // status
  output logic              calStart,
  output logic [7:0]        calCount,
  output logic              locked,
  output logic              powerDown
);
  logic [31:0]      shiftReg;
  logic             sclkPrev;
  logic             lePrev;
  logic             loadStb;
  logic [7:0][1:0]  muxSel;
  logic [7:0]       enBit;
  logic [7:0][7:0]  divVal;
  logic [7:0][3:0]  dlyVal;
  logic             globalEn;
  logic [3:0]       pllMux;
  logic [3:0]       vcoDiv;
  logic             ldPrescale;
  logic [3:0]       vcoCnt;
  logic [3:0]       vcoEff;
  logic             distTick;
  logic             distLevel;
  logic             syncMeta;
  logic             syncSafe;
  logic [3:0]       syncPipe;
  logic             syncHold;
  logic             syncRelease;
  logic [1:0]       preCnt;
  logic             lockTick;
  logic [2:0]       goodCnt;
  logic             lockPinNext;

  // serial shift on rising serial clock
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      shiftReg <= 32'h0000_0000;
      sclkPrev <= 1'b0;
      lePrev   <= 1'b0;
    end else begin
      sclkPrev <= link.serialClk;
      lePrev   <= link.latchEn;
      if (link.serialClk && !sclkPrev && !link.latchEn) begin
        shiftReg <= {shiftReg[30:0], link.serialData};
      end
    end
  end

  assign loadStb = link.latchEn && !lePrev;

  // register bank; reset bit in word 0 restores defaults too
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      muxSel     <= {8{coc_pkg::MUX_RST}};
      enBit      <= 8'h00;
      divVal     <= {8{coc_pkg::DIV_RST}};
      dlyVal     <= {8{coc_pkg::DLY_RST}};
      globalEn   <= coc_pkg::GEN_RST;
      powerDown  <= 1'b0;
      pllMux     <= coc_pkg::PLLMUX_RST;
      vcoDiv     <= coc_pkg::VCODIV_RST;
      ldPrescale <= 1'b0;
    end else if (loadStb && shiftReg[3:0] == 4'h0 && shiftReg[coc_pkg::RESET_BIT]) begin
      muxSel     <= {8{coc_pkg::MUX_RST}};
      enBit      <= 8'h00;
      divVal     <= {8{coc_pkg::DIV_RST}};
      dlyVal     <= {8{coc_pkg::DLY_RST}};
      globalEn   <= coc_pkg::GEN_RST;
      powerDown  <= 1'b0;
      pllMux     <= coc_pkg::PLLMUX_RST;
      vcoDiv     <= coc_pkg::VCODIV_RST;
      ldPrescale <= 1'b0;
    end else if (loadStb) begin
      case (shiftReg[3:0])
        4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7: begin
          muxSel[shiftReg[2:0]] <= shiftReg[coc_pkg::MUX_LSB +: 2];
          enBit[shiftReg[2:0]]  <= shiftReg[coc_pkg::EN_BIT];
          divVal[shiftReg[2:0]] <= shiftReg[coc_pkg::DIV_LSB +: 8];
          dlyVal[shiftReg[2:0]] <= shiftReg[coc_pkg::DLY_LSB +: 4];
        end
        coc_pkg::ADDR_R11: ldPrescale <= shiftReg[coc_pkg::LOCK_DETECT_PRESCALE_BIT];
        coc_pkg::ADDR_R14: begin
          globalEn  <= shiftReg[coc_pkg::GEN_BIT];
          powerDown <= shiftReg[coc_pkg::PDN_BIT];
          pllMux    <= shiftReg[coc_pkg::PLLMUX_LSB +: 4];
        end
        coc_pkg::ADDR_R15: vcoDiv <= shiftReg[coc_pkg::VCODIV_LSB +: 4];
        default: ;
      endcase
    end
  end

  // calibration restarts on every trigger register load
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      calStart <= 1'b0;
      calCount <= 8'h00;
    end else begin
      calStart <= loadStb && (shiftReg[3:0] == coc_pkg::ADDR_R15);
      if (loadStb && (shiftReg[3:0] == coc_pkg::ADDR_R15)) begin
        calCount <= calCount + 8'h01;
      end
    end
  end

  // distribution clock: high for floor(div/2) of div cycles
  assign vcoEff = (vcoDiv < 4'h2) ? 4'h2 : vcoDiv;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      vcoCnt <= 4'h0;
    end else if (vcoCnt + 4'h1 >= vcoEff) begin
      vcoCnt <= 4'h0;
    end else begin
      vcoCnt <= vcoCnt + 4'h1;
    end
  end

  assign distTick  = (vcoCnt == 4'h0);
  assign distLevel = (vcoCnt < {1'b0, vcoEff[3:1]});

  // sync path: two stages then four more distribution cycles
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      syncMeta <= 1'b1;
      syncSafe <= 1'b1;
      syncPipe <= 4'hF;
    end else if (distTick) begin
      syncMeta <= link.syncN;
      syncSafe <= syncMeta;
      syncPipe <= {syncPipe[2:0], syncSafe};
    end
  end

  // a pulse shorter than the pipe still reaches the end intact
  assign syncHold    = !syncPipe[coc_pkg::SYNC_LAG - 1];
  // release on the tick that lifts the pipe end, so hold never masks it
  assign syncRelease = distTick && syncHold && syncPipe[coc_pkg::SYNC_LAG - 2];

  genvar gi;
  generate
    for (gi = 0; gi < coc_pkg::NUM_OUT; gi++) begin : gOut
      coc_channel uChan (
        .clk         (clk),
        .rstn        (rstn),
        .distTick    (distTick),
        .distLevel   (distLevel),
        .syncHold    (syncHold && !syncRelease),
        .syncRelease (syncRelease),
        .mux         (muxSel[gi]),
        .div         (divVal[gi]),
        .dly         (dlyVal[gi]),
        .enable      (enBit[gi] & globalEn),
        .global_enable_pin         (link.global_enable_pin),
        .clkOut      (clkOut[gi]),
        .outOn       (outOn[gi]),
        .delayPs     (outDelayPs[gi])
      );
    end
  endgenerate

  // lock detect, optionally on every fourth reference cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      preCnt <= 2'h0;
    end else if (refTick) begin
      preCnt <= preCnt + 2'h1;
    end
  end

  assign lockTick = refTick && (!ldPrescale || preCnt == coc_pkg::LD_PRESCALE);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      goodCnt <= 3'h0;
      locked  <= 1'b0;
    end else if (lockTick) begin
      if (!locked) begin
        if (phaseErrNs >= coc_pkg::LOCK_EPS_NS) begin
          goodCnt <= 3'h0;
        end else if (goodCnt + 3'h1 >= coc_pkg::LOCK_COUNT) begin
          goodCnt <= 3'h0;
          locked  <= 1'b1;
        end else begin
          goodCnt <= goodCnt + 3'h1;
        end
      end else if (phaseErrNs > coc_pkg::LOCK_DEL_NS) begin
        locked <= 1'b0;
      end
    end
  end

  always_comb begin
    case (pllMux)
      coc_pkg::LD_ACT_HIGH: lockPinNext = locked && !powerDown;
      coc_pkg::LD_ACT_LOW:  lockPinNext = !(locked && !powerDown);
      default:              lockPinNext = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      link.lockPin <= 1'b0;
    end else begin
      link.lockPin <= lockPinNext;
    end
  end
endmodule // coc_device

// *** rtl/coc_host.sv ***
// host end: wishbone slave that sends 32-bit words over the serial link
// assumes classic wishbone master on the same clock
`timescale 1ns/10ps
module coc_host (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // wishbone slave
  input  wire logic         wb_cyc_i,
  input  wire logic         wb_stb_i,
  input  wire logic         wb_we_i,
  input  wire logic [3:0]   wb_adr_i,
  input  wire logic [3:0]   wb_sel_i,
  input  wire logic [31:0]  wb_dat_i,
  output logic [31:0]       wb_dat_o,
  output logic              wb_ack_o,
  // link
  coc_link_if.host          link
);
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_LOW   = 5'h02,
    ST_HIGH  = 5'h04,
    ST_LATCH = 5'h08,
    ST_END   = 5'h10
  } coc_hstate_t;

  coc_hstate_t state;
  logic [31:0] word;
  logic [4:0]  bitCnt;
  logic [7:0]  divCnt;
  logic        tick;
  logic [1:0]  ctrl;
  logic        wbReq;
  logic        wordWr;

  assign wbReq  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wordWr = wbReq && wb_we_i && wb_adr_i == coc_pkg::WB_WORD && (&wb_sel_i)
                  && state == ST_IDLE;

  // half-period enable pulse
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      divCnt <= 8'h00;
    end else if (state == ST_IDLE || divCnt + 8'h01 >= 8'(coc_pkg::HALF_CYC)) begin
      divCnt <= 8'h00;
    end else begin
      divCnt <= divCnt + 8'h01;
    end
  end

  assign tick = (state != ST_IDLE) && (divCnt + 8'h01 >= 8'(coc_pkg::HALF_CYC));

  // serial sequence: data on low phase, clock high, then latch pulse
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state           <= ST_IDLE;
      word            <= 32'h0000_0000;
      bitCnt          <= 5'h00;
      link.serialClk  <= 1'b0;
      link.serialData <= 1'b0;
      link.latchEn    <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (wordWr) begin
            word            <= {wb_dat_i[30:0], 1'b0};
            link.serialData <= wb_dat_i[31];
            bitCnt          <= 5'h1F;
            state           <= ST_LOW;
          end
        end
        ST_LOW: if (tick) begin
          link.serialClk <= 1'b1;
          state          <= ST_HIGH;
        end
        ST_HIGH: if (tick) begin
          link.serialClk <= 1'b0;
          if (bitCnt == 5'h00) begin
            link.serialData <= 1'b0;
            state           <= ST_LATCH;
          end else begin
            link.serialData <= word[31];
            word            <= {word[30:0], 1'b0};
            bitCnt          <= bitCnt - 5'h01;
            state           <= ST_LOW;
          end
        end
        ST_LATCH: if (tick) begin
          link.latchEn <= 1'b1;
          state        <= ST_END;
        end
        ST_END: if (tick) begin
          link.latchEn    <= 1'b0;
          link.serialClk  <= 1'b0;
          link.serialData <= 1'b0;
          state           <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // control pins idle high like the device pull-ups
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl <= coc_pkg::CTRL_RST;
    end else if (wbReq && wb_we_i && wb_adr_i == coc_pkg::WB_CTRL && wb_sel_i[0]) begin
      ctrl <= wb_dat_i[1:0];
    end
  end

  assign link.syncN = ctrl[0];
  assign link.global_enable_pin   = ctrl[1];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wbReq;
      case (wb_adr_i)
        coc_pkg::WB_STATUS: wb_dat_o <= {30'h0, link.lockPin, state != ST_IDLE};
        coc_pkg::WB_CTRL:   wb_dat_o <= {30'h0, ctrl};
        default:            wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end
endmodule // coc_host

// *** testbench/coc_props.sv ***
// checker: link pin relations between the host and device ends
// assumes every link pin is sampled on the shared rising clock
`timescale 1ns/10ps
module coc_props (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // link pins
  input wire logic serialClk,
  input wire logic serialData,
  input wire logic latchEn,
  input wire logic syncN,
  input wire logic global_enable_pin,
  input wire logic lockPin
);
  logic [5:0] bitCnt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // shifted bits since last latch; a short word shows up at the latch
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bitCnt <= 6'h00;
    end else if (latchEn) begin
      bitCnt <= 6'h00;
    end else if ($rose(serialClk)) begin
      bitCnt <= bitCnt + 6'h01;
    end
  end
  sequence s_bit;
    serialClk ##1 !serialClk;
  endsequence
  sequence s_latch;
    latchEn ##1 (!latchEn && !serialClk && !serialData) [*2];
  endsequence
  a_data_held: assert property ($rose(serialClk) |-> $stable(serialData))
    else $error("data moved at clock rise");
  a_data_change: assert property ($changed(serialData) |-> !serialClk)
    else $error("data changed while clock high");
  a_clk_pulse: assert property ($rose(serialClk) |-> s_bit)
    else $error("serial clock high too long");
  a_bit_spacing: assert property ($rose(serialClk) && bitCnt < 6'h1F |-> ##2 $rose(serialClk))
    else $error("bits not back to back");
  a_word_length: assert property ($rose(latchEn) |-> bitCnt == 6'h20)
    else $error("latch without 32 bits");
  a_latch_end: assert property ($rose(latchEn) |-> s_latch)
    else $error("lines not low after latch");
  a_no_shift_latch: assert property (latchEn |-> !serialClk)
    else $error("clock high during latch");
  a_reset_idle: assert property ($rose(rstn) |-> syncN && global_enable_pin && !latchEn && !lockPin)
    else $error("link not idle after reset");
endmodule // coc_props

// *** testbench/test_clock_output_sync_control.sv ***
// bench: host and device ends joined by the link, driven over wishbone
// assumes one shared clock; reference ticks and phase error come from here
`timescale 1ns/10ps
module test_clock_output_sync_control;
  logic             clk = 1'b0;
  logic             rstn = 1'b0;
  logic             cyc = 1'b0;
  logic             stb = 1'b0;
  logic             we = 1'b0;
  logic [3:0]       adr = 4'h0;
  logic [3:0]       sel = 4'h0;
  logic [31:0]      dat = 32'h0;
  logic             refTick = 1'b0;
  logic [7:0]       phaseErrNs = 8'h00;
  logic [31:0]      rdat;
  logic             ack;
  logic [7:0]       clkOut;
  logic [7:0]       outOn;
  logic [7:0][11:0] outDelayPs;
  logic [7:0]       calCount;
  logic             calStart;
  int               calPulses = 0;
  logic             locked;
  logic             powerDown;
  logic [31:0]      q;
  logic [7:0]       c0;
  int               errors = 0;
  int               n_tests = 0;
  int               cycles = 0;
  int               hi;
  int               tg;
  int               n;
  coc_link_if lnk ();
  coc_host i_coc_host (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .link(lnk));
  coc_device i_coc_device (.clk(clk), .rstn(rstn), .link(lnk), .refTick(refTick),
    .phaseErrNs(phaseErrNs), .clkOut(clkOut), .outOn(outOn), .outDelayPs(outDelayPs),
    .calStart(calStart), .calCount(calCount), .locked(locked), .powerDown(powerDown));
  coc_props i_coc_props (.clk(clk), .rstn(rstn), .serialClk(lnk.serialClk),
    .serialData(lnk.serialData), .latchEn(lnk.latchEn), .syncN(lnk.syncN), .global_enable_pin(lnk.global_enable_pin),
    .lockPin(lnk.lockPin));
  always #12.5 clk = ~clk;
  // one pulse expected per trigger register load
  always @(posedge clk) begin
    if (calStart === 1'b1) begin
      calPulses++;
    end
  end
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ceiling well above the fewer than two thousand cycles the tests need
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      $display("FAIL %0t timeout", $time);
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("FAIL %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask
  // one word over the link, then wait for the host to go idle
  task automatic send(input logic [31:0] w);
    wb(1'b1, coc_pkg::WB_WORD, 4'hF, w);
    do wb(1'b0, coc_pkg::WB_STATUS, 4'hF, 32'h0); while (q[0] !== 1'b0);
    repeat (2) @(posedge clk);
  endtask
  task automatic watch(input int k, input int i);
    logic p;
    p = clkOut[i];
    hi = 0;
    tg = 0;
    repeat (k) begin
      @(posedge clk);
      hi += int'(clkOut[i] === 1'b1);
      tg += int'(clkOut[i] !== p);
      p = clkOut[i];
    end
  endtask
  task automatic tick(input int k, input logic [7:0] e);
    phaseErrNs <= e;
    repeat (k) begin
      refTick <= 1'b1;
      @(posedge clk);
      refTick <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk(outOn, 32'h0, "outputs on");
    chk(clkOut, 32'h0, "clocks");
    chk(outDelayPs[1], 32'h0, "delay");
    wb(1'b0, coc_pkg::WB_CTRL, 4'hF, 32'h0);
    chk(q, 32'(coc_pkg::CTRL_RST), "ctrl");
    wb(1'b0, 4'hC, 4'hF, 32'h0);
    chk(q, 32'h0, "unmapped");
    $display("test reset done");
    send(32'h8000_0000);
    wb(1'b1, coc_pkg::WB_WORD, 4'h1, 32'h0001_0000);
    send(32'h0003_04F1);
    send(32'h0001_0012);
    send(32'h0003_0203);
    chk(outOn, 32'h0E, "enables");
    chk(outDelayPs[1], 32'(coc_pkg::DLY_MAX_PS), "max delay");
    chk(outDelayPs[2], 32'(coc_pkg::DLY_STEP_PS), "one step");
    send(32'h0000_000E);
    chk(outOn, 32'h0, "global off");
    send(32'h0800_000E);
    chk(outOn, 32'h0E, "global on");
    wb(1'b1, coc_pkg::WB_CTRL, 4'hF, 32'h1);
    watch(24, 2);
    chk(hi, 0, "pin low");
    wb(1'b1, coc_pkg::WB_CTRL, 4'hF, 32'h3);
    watch(24, 2);
    chk(tg > 0, 1, "pin high");
    $display("test gating done");
    c0 = calCount;
    // reference kept running while the trigger register is written
    fork
      tick(40, 8'h32);
      send(32'h0C00_000F);
    join
    watch(24, 1);
    watch(30, 2);
    chk(hi, 10, "bypass duty");
    watch(24, 1);
    chk(hi, 12, "divided duty");
    send(32'h0800_000F);
    send(32'h0800_000F);
    chk(calCount, c0 + 8'd3, "cal count");
    chk(calPulses, 32'h3, "cal pulses");
    $display("test duty done");
    wb(1'b1, coc_pkg::WB_CTRL, 4'hF, 32'h2);
    watch(30, 1);
    watch(40, 1);
    chk(hi, 0, "sync holds divided");
    watch(40, 2);
    chk(tg > 0, 1, "bypass runs");
    wb(1'b1, coc_pkg::WB_CTRL, 4'hF, 32'h3);
    n = 0;
    while (clkOut[1] !== 1'b1 && n < 60) begin
      @(posedge clk);
      n++;
    end
    chk(n >= 2 * coc_pkg::SYNC_LAG - 1 && n <= 2 * coc_pkg::SYNC_LAG + 12, 1, "lag");
    chk(clkOut[3], 1'b1, "rise together");
    $display("test sync done");
    send(32'h0830_000E);
    tick(4, 8'd5);
    chk(locked, 1'b0, "early lock");
    tick(1, 8'd5);
    chk(locked, 1'b1, "lock");
    chk(lnk.lockPin, 1'b1, "pin high lock");
    wb(1'b0, coc_pkg::WB_STATUS, 4'hF, 32'h0);
    chk(q, 32'h2, "status lock");
    tick(1, 8'd15);
    chk(locked, 1'b1, "hysteresis");
    tick(1, 8'd25);
    chk(locked, 1'b0, "unlock");
    send(32'h0000_800B);
    tick(16, 8'd5);
    chk(locked, 1'b0, "prescaled early");
    tick(4, 8'd5);
    chk(locked, 1'b1, "prescaled lock");
    send(32'h0840_000E);
    chk(lnk.lockPin, 1'b0, "pin low lock");
    send(32'h0C40_000E);
    chk(powerDown, 1'b1, "power down");
    chk(lnk.lockPin, 1'b1, "no-lock level");
    $display("test lock done");
    end_of_test();
  end
endmodule // test_clock_output_sync_control
